// *** cms_pkg.sv ***
// Package: register map, fields and types of the CRC memory scanner slice
package cms_pkg;

	// Register offsets (byte addresses of our own choosing)
	localparam logic [3:0] CMS_ADDR_ACCUM_LOW  = 4'h0;
	localparam logic [3:0] CMS_ADDR_SHIFT_HIGH = 4'h1;
	localparam logic [3:0] CMS_ADDR_SHIFT_LOW  = 4'h2;
	localparam logic [3:0] CMS_ADDR_TAPS_HIGH  = 4'h3;
	localparam logic [3:0] CMS_ADDR_TAPS_LOW   = 4'h4;
	localparam logic [3:0] CMS_ADDR_SCAN_CTRL  = 4'h5;
	localparam logic [3:0] CMS_ADDR_CUR_HIGH   = 4'h6;
	localparam logic [3:0] CMS_ADDR_CUR_LOW    = 4'h7;
	localparam logic [3:0] CMS_ADDR_END_HIGH   = 4'h8;
	localparam logic [3:0] CMS_ADDR_END_LOW    = 4'h9;
	localparam logic [3:0] CMS_ADDR_IRQ_STAT   = 4'ha;
	localparam logic [3:0] CMS_ADDR_IRQ_MASK   = 4'hb;

	// Control register field positions
	localparam int CMS_CTRL_EN      = 7;
	localparam int CMS_CTRL_GO      = 6;
	localparam int CMS_CTRL_BUSY    = 5;
	localparam int CMS_CTRL_INVALID = 4;
	localparam int CMS_CTRL_IRQ_MANAGE_SEL    = 3;
	localparam int CMS_CTRL_MODE_HI = 1;
	localparam int CMS_CTRL_MODE_LO = 0;

	// Interrupt status bits
	localparam int CMS_IRQ_DONE    = 0;
	localparam int CMS_IRQ_INVALID = 1;
	localparam logic [7:0] CMS_IRQ_IMPL = 8'h03;

	// Reset values and limits
	localparam logic [7:0]  CMS_BYTE_ZERO   = 8'h00;
	localparam logic [15:0] CMS_WORD_ZERO   = 16'h0000;
	localparam logic [15:0] CMS_ADDR_ONE    = 16'h0001;
	localparam logic [15:0] CMS_MEM_LIMIT   = 16'h4000;
	localparam logic [7:0]  CMS_TAPS_LOW_MASK = 8'hfe;
	localparam logic [7:0]  CMS_CTRL_RD_MASK  = 8'hfb;

	typedef enum logic [1:0] {
		CMS_MODE_CONCURRENT = 2'h0,
		CMS_MODE_BURST      = 2'h1,
		CMS_MODE_PEEK       = 2'h2,
		CMS_MODE_TRIGGERED  = 2'h3
	} cms_mode_t;

	typedef enum logic [1:0] {
		CMS_ST_IDLE,
		CMS_ST_FETCH,
		CMS_ST_HAND
	} cms_state_t;

	// Register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cms_bus_t;

	// Scan control fields
	typedef struct packed {
		logic      en;
		logic      go;
		logic      irq_manage_sel;
		cms_mode_t mode;
	} cms_ctrl_t;

	// Program flash read request
	typedef struct packed {
		logic        req;
		logic [15:0] addr;
	} cms_fetch_t;

endpackage

// *** cms_scan_fsm.sv ***
// Scanner fetch sequencer: flash read per engine ready
`timescale 1ns/1ps
`default_nettype none
module cms_scan_fsm
	import cms_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// Control
	input  wire logic        run_in,
	input  wire logic        engine_ready_in,
	input  wire logic [15:0] addr_in,
	// Flash read port
	output logic             flash_req_out,
	output logic      [15:0] flash_addr_out,
	input  wire logic        flash_ack_in,
	input  wire logic [15:0] flash_rdata_in,
	// Hand-over to engine
	output logic             word_valid_out,
	output logic      [15:0] word_out,
	output logic             fetched_out,
	output logic             active_out
);

	typedef struct packed {
		cms_state_t  st;
		logic [15:0] addr;
		logic [15:0] word;
		logic        valid;
	} fsm_state_t;

	fsm_state_t s_q;
	fsm_state_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.valid = 1'b0;
		unique case (s_q.st)
			CMS_ST_IDLE: begin
				if (run_in && engine_ready_in) begin
					s_d.st = CMS_ST_FETCH;
					s_d.addr = addr_in;
				end
			end
			CMS_ST_FETCH: begin
				// Fetch completes even if run drops, keeping the address honest
				if (flash_ack_in) begin
					s_d.word = flash_rdata_in;
					s_d.st = CMS_ST_HAND;
				end
			end
			CMS_ST_HAND: begin
				s_d.valid = 1'b1;
				s_d.st = CMS_ST_IDLE;
			end
		endcase
		if (!run_in && s_q.st == CMS_ST_IDLE) begin
			s_d.st = CMS_ST_IDLE;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			s_q <= '{st: CMS_ST_IDLE, addr: CMS_WORD_ZERO,
				word: CMS_WORD_ZERO, valid: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign flash_req_out  = (s_q.st == CMS_ST_FETCH);
	assign flash_addr_out = s_q.addr;
	assign word_valid_out = s_q.valid;
	assign word_out       = s_q.word;
	assign fetched_out    = (s_q.st == CMS_ST_FETCH) && flash_ack_in;
	assign active_out     = (s_q.st != CMS_ST_IDLE);

endmodule
`default_nettype wire

// *** cms_regs.sv ***
// Top: CRC and scanner register slice with scan sequencer and interrupt
//
// How it works
// RULE_01: Accumulator low byte writes go to engine write path; reads return it.
// RULE_02: Shifter bytes are read-only live shifter contents; writes ignored.
// RULE_03: Tap bits 15..1 enable polynomial feedback; low bit 0 reads zero.
// RULE_04: Enable clear disables scanner and resets its sequencer.
// RULE_05: Enable clear leaves every other register unchanged.
// RULE_06: Go set fetches per selected mode on each engine ready; else none.
// RULE_07: Hardware clears go once current exceeds end, outside a data cycle.
// RULE_08: With interrupt management, interrupt response masks go, keeps stored bit.
// RULE_09: Busy reads one while fetching or while go is set and engine signals ready.
// RULE_10: Invalid flag set when current address reaches beyond implemented memory.
// RULE_11: Peek mode ignores the interrupt management bit.
// RULE_12: Burst mode: management suspends scan in interrupts; else scan continues.
// RULE_13: Concurrent/triggered: management suspends access in interrupts; else unblocked.
// RULE_14: Mode field 11 triggered, 10 peek, 01 burst, 00 concurrent; bit 2 zero.
// RULE_15: Current address holds written start and increments after each fetch.
// RULE_16: Current address writes ignored while go is set.
// RULE_17: Software touches current address bytes only while go is clear.
// RULE_18: End address pair holds last scan address; writes ignored while go set.
// RULE_19: Reset returns all registers to reset values, busy and invalid clear.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cms_regs
	import cms_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// Register port
	input  wire logic [3:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [7:0]  reg_rdata_out,
	// CRC engine side
	input  wire logic [7:0]  accum_low_in,
	input  wire logic [15:0] shifter_in,
	input  wire logic        engine_ready_in,
	output logic             accum_low_we_out,
	output logic      [7:0]  accum_low_wdata_out,
	output logic      [15:0] poly_taps_out,
	output logic             word_valid_out,
	output logic      [15:0] word_out,
	// Core side
	input  wire logic        irq_active_in,
	input  wire logic        trigger_in,
	output logic             cpu_stall_out,
	// Program flash read port
	output logic             flash_req_out,
	output logic      [15:0] flash_addr_out,
	input  wire logic        flash_ack_in,
	input  wire logic [15:0] flash_rdata_in,
	// Interrupt
	output logic             irq_out
);

	typedef struct packed {
		cms_ctrl_t   ctrl;
		logic [15:0] taps;
		logic [15:0] cur;
		logic [15:0] last;
		logic [7:0]  stat;
		logic [7:0]  mask;
		logic [7:0]  rdata;
		logic        aw;
		logic [7:0]  awd;
		logic        trig;
	} regs_state_t;

	regs_state_t s_q;
	regs_state_t s_d;
	cms_bus_t    bus;
	logic        run;
	logic        go_eff;
	logic        fetched;
	logic        active;
	logic        busy;
	logic        invalid;
	logic        past_end;
	logic [7:0]  rd_val;
	logic [7:0]  ev;

	////////////////////////////////////////////////////////////////////////
	// Derived status

	assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in,
		wr: reg_wr_in, rd: reg_rd_in};

	// Peek mode never masks go
	always_comb begin
		go_eff = s_q.ctrl.en && s_q.ctrl.go;
		if (s_q.ctrl.irq_manage_sel && irq_active_in &&
			s_q.ctrl.mode != CMS_MODE_PEEK) begin // RULE_11
			go_eff = 1'b0; // RULE_08 RULE_12 RULE_13
		end
	end

	// Triggered mode waits for a trigger pulse per word
	always_comb begin
		run = go_eff && !past_end && !invalid; // RULE_06
		if (s_q.ctrl.mode == CMS_MODE_TRIGGERED) begin
			run = run && s_q.trig;
		end
	end

	assign past_end = (s_q.cur > s_q.last); // RULE_07
	assign invalid  = (s_q.cur >= CMS_MEM_LIMIT); // RULE_10
	assign busy     = s_q.ctrl.en &&
		(active || (s_q.ctrl.go && engine_ready_in)); // RULE_09

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	cms_scan_fsm u_fsm (
		.sys_clk_in      (sys_clk_in),
		.rst_in          (rst_in || !s_q.ctrl.en), // RULE_04
		.run_in          (run),
		.engine_ready_in (engine_ready_in),
		.addr_in         (s_q.cur),
		.flash_req_out   (flash_req_out),
		.flash_addr_out  (flash_addr_out),
		.flash_ack_in    (flash_ack_in),
		.flash_rdata_in  (flash_rdata_in),
		.word_valid_out  (word_valid_out),
		.word_out        (word_out),
		.fetched_out     (fetched),
		.active_out      (active)
	);

	////////////////////////////////////////////////////////////////////////
	// Read mux

	always_comb begin
		rd_val = CMS_BYTE_ZERO;
		unique case (bus.addr)
			CMS_ADDR_ACCUM_LOW:  rd_val = accum_low_in; // RULE_01
			CMS_ADDR_SHIFT_HIGH: rd_val = shifter_in[15:8]; // RULE_02
			CMS_ADDR_SHIFT_LOW:  rd_val = shifter_in[7:0]; // RULE_02
			CMS_ADDR_TAPS_HIGH:  rd_val = s_q.taps[15:8];
			CMS_ADDR_TAPS_LOW:   rd_val = s_q.taps[7:0] & CMS_TAPS_LOW_MASK;
			CMS_ADDR_SCAN_CTRL: begin
				rd_val[CMS_CTRL_EN]      = s_q.ctrl.en;
				rd_val[CMS_CTRL_GO]      = s_q.ctrl.go;
				rd_val[CMS_CTRL_BUSY]    = busy;
				rd_val[CMS_CTRL_INVALID] = invalid;
				rd_val[CMS_CTRL_IRQ_MANAGE_SEL]    = s_q.ctrl.irq_manage_sel;
				rd_val[CMS_CTRL_MODE_HI:CMS_CTRL_MODE_LO] = s_q.ctrl.mode;
				rd_val = rd_val & CMS_CTRL_RD_MASK; // RULE_14
			end
			CMS_ADDR_CUR_HIGH:   rd_val = s_q.cur[15:8];
			CMS_ADDR_CUR_LOW:    rd_val = s_q.cur[7:0];
			CMS_ADDR_END_HIGH:   rd_val = s_q.last[15:8];
			CMS_ADDR_END_LOW:    rd_val = s_q.last[7:0];
			CMS_ADDR_IRQ_STAT:   rd_val = s_q.stat;
			CMS_ADDR_IRQ_MASK:   rd_val = s_q.mask;
			default:             rd_val = CMS_BYTE_ZERO;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		ev = CMS_BYTE_ZERO;
		s_d = s_q;
		s_d.aw = 1'b0;
		s_d.rdata = bus.rd ? rd_val : CMS_BYTE_ZERO;
		if (fetched) begin
			s_d.trig = 1'b0;
			s_d.cur = s_q.cur + CMS_ADDR_ONE; // RULE_15
		end
		// A trigger in the fetch cycle arms the next word, never lost
		if (trigger_in) begin
			s_d.trig = 1'b1;
		end
		if (bus.wr) begin
			unique case (bus.addr)
				CMS_ADDR_ACCUM_LOW: begin
					s_d.aw = 1'b1; // RULE_01
					s_d.awd = bus.wdata;
				end
				CMS_ADDR_TAPS_HIGH: s_d.taps[15:8] = bus.wdata; // RULE_03
				CMS_ADDR_TAPS_LOW:
					s_d.taps[7:0] = bus.wdata & CMS_TAPS_LOW_MASK; // RULE_03
				CMS_ADDR_SCAN_CTRL: begin
					// Only control fields change; others untouched
					s_d.ctrl.en   = bus.wdata[CMS_CTRL_EN]; // RULE_04 RULE_05
					s_d.ctrl.go   = bus.wdata[CMS_CTRL_GO];
					s_d.ctrl.irq_manage_sel = bus.wdata[CMS_CTRL_IRQ_MANAGE_SEL];
					s_d.ctrl.mode = cms_mode_t'(
						bus.wdata[CMS_CTRL_MODE_HI:CMS_CTRL_MODE_LO]); // RULE_14
				end
				CMS_ADDR_CUR_HIGH:
					if (!s_q.ctrl.go) s_d.cur[15:8] = bus.wdata; // RULE_16 RULE_17
				CMS_ADDR_CUR_LOW:
					if (!s_q.ctrl.go) s_d.cur[7:0] = bus.wdata; // RULE_16 RULE_17
				CMS_ADDR_END_HIGH:
					if (!s_q.ctrl.go) s_d.last[15:8] = bus.wdata; // RULE_18
				CMS_ADDR_END_LOW:
					if (!s_q.ctrl.go) s_d.last[7:0] = bus.wdata; // RULE_18
				CMS_ADDR_IRQ_MASK:  s_d.mask = bus.wdata & CMS_IRQ_IMPL;
				default: ;
			endcase
		end
		// Clear only after the last fetch lands
		if (s_q.ctrl.go && (past_end || invalid) && !active) begin
			s_d.ctrl.go = 1'b0; // RULE_07
			ev[CMS_IRQ_DONE] = 1'b1;
		end
		if (fetched && (s_q.cur + CMS_ADDR_ONE) >= CMS_MEM_LIMIT) begin
			ev[CMS_IRQ_INVALID] = 1'b1; // RULE_10
		end
		// Read clears status; a new event in the same cycle wins
		if (bus.rd && bus.addr == CMS_ADDR_IRQ_STAT) begin
			s_d.stat = CMS_BYTE_ZERO;
		end
		s_d.stat = s_d.stat | ev;
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			s_q <= '{ctrl: '{en: 1'b0, go: 1'b0, irq_manage_sel: 1'b0,
				mode: CMS_MODE_CONCURRENT},
				taps: CMS_WORD_ZERO, cur: CMS_WORD_ZERO,
				last: CMS_WORD_ZERO, stat: CMS_BYTE_ZERO,
				mask: CMS_BYTE_ZERO, rdata: CMS_BYTE_ZERO,
				aw: 1'b0, awd: CMS_BYTE_ZERO, trig: 1'b0}; // RULE_19
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign reg_rdata_out       = s_q.rdata;
	assign accum_low_we_out    = s_q.aw;
	assign accum_low_wdata_out = s_q.awd;
	assign poly_taps_out       = s_q.taps;
	// Burst stalls the core unless an interrupt suspends the scan
	assign cpu_stall_out = s_q.ctrl.mode == CMS_MODE_BURST && go_eff &&
		!past_end && !invalid; // RULE_12
	assign irq_out = |(s_q.stat & s_q.mask);

endmodule
`default_nettype wire

// *** cms_regs_properties.sv ***
// Checker: port-level assertions of the scanner register slice
`timescale 1ns/1ps
`default_nettype none
module cms_regs_properties
	import cms_pkg::*;
(
	// Clock, reset, register port
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	input wire logic [3:0]  reg_addr_in,
	input wire logic [7:0]  reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [7:0]  reg_rdata_out,
	// Engine, flash, interrupt
	input wire logic        engine_ready_in,
	input wire logic        accum_low_we_out,
	input wire logic [7:0]  accum_low_wdata_out,
	input wire logic [15:0] poly_taps_out,
	input wire logic        word_valid_out,
	input wire logic [15:0] word_out,
	input wire logic        flash_req_out,
	input wire logic [15:0] flash_addr_out,
	input wire logic        flash_ack_in,
	input wire logic [15:0] flash_rdata_in,
	input wire logic        irq_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	wire logic wr_acc = reg_wr_in && reg_addr_in == CMS_ADDR_ACCUM_LOW;
	wire logic wr_th = reg_wr_in && reg_addr_in == CMS_ADDR_TAPS_HIGH;
	wire logic wr_tl = reg_wr_in && reg_addr_in == CMS_ADDR_TAPS_LOW;
	////////////////////////////////////////////////////////////////////////
	acc_write_a: assert property (wr_acc |=> accum_low_we_out &&
		accum_low_wdata_out == $past(reg_wdata_in)) else $error("acc write");
	taps_high_a: assert property (wr_th |=>
		poly_taps_out[15:8] == $past(reg_wdata_in)) else $error("taps high");
	taps_low_a: assert property (wr_tl |=> poly_taps_out[7:0] ==
		($past(reg_wdata_in) & CMS_TAPS_LOW_MASK)) else $error("taps low");
	fetch_cause_a: assert property ($rose(flash_req_out) |->
		$past(engine_ready_in)) else $error("fetch without ready");
	req_hold_a: assert property (flash_req_out && !flash_ack_in |=>
		flash_req_out && $stable(flash_addr_out)) else $error("req dropped");
	hand_over_a: assert property (flash_req_out && flash_ack_in |=>
		!flash_req_out ##1 word_valid_out &&
		word_out == $past(flash_rdata_in, 2)) else $error("word lost");
	word_pulse_a: assert property (word_valid_out |=>
		!word_valid_out) else $error("word valid too long");
	// Own disable: must hold through reset itself
	reset_quiet_a: assert property (disable iff (1'b0) rst_in |=>
		!flash_req_out && !word_valid_out && !irq_out &&
		reg_rdata_out == 8'h00) else $error("busy after reset");
	cover property (word_valid_out);
	cover property ($rose(irq_out));
	cover property (flash_req_out && flash_ack_in);
endmodule
bind cms_regs cms_regs_properties cms_regs_properties_inst (.sys_clk_in,
	.rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
	.reg_rdata_out, .engine_ready_in, .accum_low_we_out,
	.accum_low_wdata_out, .poly_taps_out, .word_valid_out, .word_out,
	.flash_req_out, .flash_addr_out, .flash_ack_in, .flash_rdata_in,
	.irq_out);
`default_nettype wire

// *** cms_flash_model.sv ***
// Partner: program flash read port, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module cms_flash_model (
	// Clock and reset
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	// Read port
	input wire logic        req_in,
	input wire logic [15:0] addr_in,
	input wire logic        slow_in,
	output logic            ack_out,
	output logic     [15:0] rdata_out,
	output logic     [7:0]  count_out
);
	logic [1:0] wait_q;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ack_out <= 1'b0;
			wait_q <= 2'h0;
			count_out <= 8'h00;
		end else if (req_in && !ack_out) begin
			if (wait_q == (slow_in ? 2'h2 : 2'h0)) begin
				ack_out <= 1'b1;
				count_out <= count_out + 8'h01;
				wait_q <= 2'h0;
			end else begin
				wait_q <= wait_q + 2'h1;
			end
		end else begin
			ack_out <= 1'b0;
		end
	end
	// Released data inverted so a late sample never looks right
	assign rdata_out = ack_out ? addr_in ^ 16'h5a5a : ~(addr_in ^ 16'h5a5a);
endmodule
`default_nettype wire

// *** cms_regs_tb_top.sv ***
// Testbench: register-level scenarios of the scanner slice
`timescale 1ns/1ps
`default_nettype none
module cms_regs_tb_top
	import cms_pkg::*;
;
	logic sys_clk_in, rst_in, reg_wr_in, reg_rd_in, engine_ready_in;
	logic irq_active_in, trigger_in, slow, accum_low_we_out, word_valid_out;
	logic cpu_stall_out, flash_req_out, flash_ack_in, irq_out;
	logic [3:0] reg_addr_in;
	logic [7:0] reg_wdata_in, accum_low_in, reg_rdata_out, accum_low_wdata_out;
	logic [7:0] fetches, rd;
	logic [15:0] shifter_in, poly_taps_out, word_out, flash_addr_out;
	logic [15:0] flash_rdata_in;
	int n_fail, comparisons, cyc;
	cms_regs cms_regs_inst (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .accum_low_in, .shifter_in,
		.engine_ready_in, .accum_low_we_out, .accum_low_wdata_out,
		.poly_taps_out, .word_valid_out, .word_out, .irq_active_in,
		.trigger_in, .cpu_stall_out, .flash_req_out, .flash_addr_out,
		.flash_ack_in, .flash_rdata_in, .irq_out);
	cms_flash_model cms_flash_model_inst (.sys_clk_in, .rst_in,
		.req_in(flash_req_out), .addr_in(flash_addr_out), .slow_in(slow),
		.ack_out(flash_ack_in), .rdata_out(flash_rdata_in),
		.count_out(fetches));
	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rdr(input logic [3:0] a);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1 rd = reg_rdata_out;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e, string n);
		rdr(a);
		chk(n, 16'(rd), 16'(e));
	endtask
	// Pair written high byte first, only while go is clear
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr(a, v[15:8]);
		wr(a + 4'h1, v[7:0]);
	endtask
	task automatic range(input logic [15:0] lo, hi);
		wr16(CMS_ADDR_CUR_HIGH, lo);
		wr16(CMS_ADDR_END_HIGH, hi);
	endtask
	task automatic wait_go;
		for (int i = 0; i < 300; i++) begin
			rdr(CMS_ADDR_SCAN_CTRL);
			if (!rd[CMS_CTRL_GO]) break;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	// Whole run is near 250 cycles
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		{reg_wr_in, reg_rd_in, engine_ready_in, irq_active_in} = 4'h0;
		{trigger_in, slow, reg_addr_in, reg_wdata_in} = 14'h0000;
		rst_in = 1'b1;
		shifter_in = 16'hc3a5;
		accum_low_in = 8'h3c;
		tick(20);
		rst_in <= 1'b0;
		for (int a = 5; a < 10; a++) rdc(4'(a), 8'h00, "reset");
		wr(CMS_ADDR_SHIFT_HIGH, 8'hff);
		rdc(CMS_ADDR_SHIFT_HIGH, 8'hc3, "shift");
		rdc(CMS_ADDR_SHIFT_LOW, 8'ha5, "shift");
		wr(CMS_ADDR_ACCUM_LOW, 8'h5a);
		rdc(CMS_ADDR_ACCUM_LOW, 8'h3c, "accum");
		wr(CMS_ADDR_TAPS_HIGH, 8'ha5);
		wr(CMS_ADDR_TAPS_LOW, 8'hff);
		rdc(CMS_ADDR_TAPS_LOW, 8'hfe, "taps");
		chk("taps", poly_taps_out, 16'ha5fe);
		rdc(4'hf, 8'h00, "unmapped");
		for (int m = 0; m < 4; m++) begin
			wr(CMS_ADDR_SCAN_CTRL, 8'(m) | 8'h04);
			rdc(CMS_ADDR_SCAN_CTRL, 8'(m), "mode");
		end
		// Engine stalled, so go stays set
		range(16'h0010, 16'h0011);
		wr(CMS_ADDR_SCAN_CTRL, 8'hc0);
		wr(CMS_ADDR_CUR_LOW, 8'h55);
		rdc(CMS_ADDR_CUR_LOW, 8'h10, "cur_lock");
		wr(CMS_ADDR_END_LOW, 8'h99);
		rdc(CMS_ADDR_END_LOW, 8'h11, "end_lock");
		chk("idle", 16'(fetches), 16'h0000);
		engine_ready_in <= 1'b1;
		rdc(CMS_ADDR_SCAN_CTRL, 8'he0, "busy");
		wait_go();
		chk("count", 16'(fetches), 16'h0002);
		rdc(CMS_ADDR_CUR_LOW, 8'h12, "cur_inc");
		rdc(CMS_ADDR_SCAN_CTRL, 8'h80, "done");
		chk("irq", 16'(irq_out), 16'h0000);
		wr(CMS_ADDR_IRQ_MASK, 8'h03);
		tick(1);
		chk("irq", 16'(irq_out), 16'h0001);
		rdc(CMS_ADDR_IRQ_STAT, 8'h01, "status");
		tick(1);
		chk("irq", 16'(irq_out), 16'h0000);
		// Scan held off in interrupt by management, slow flash
		slow <= 1'b1;
		irq_active_in <= 1'b1;
		range(16'h3ffe, 16'h3fff);
		wr(CMS_ADDR_SCAN_CTRL, 8'hc8);
		tick(10);
		chk("irq_manage_sel", 16'(fetches), 16'h0002);
		rdr(CMS_ADDR_SCAN_CTRL);
		chk("go_kept", 16'(rd[CMS_CTRL_GO]), 16'h0001);
		irq_active_in <= 1'b0;
		wait_go();
		chk("count", 16'(fetches), 16'h0004);
		rdc(CMS_ADDR_CUR_HIGH, 8'h40, "cur_top");
		rdc(CMS_ADDR_SCAN_CTRL, 8'h98, "invalid");
		rdc(CMS_ADDR_IRQ_STAT, 8'h03, "status");
		wr(CMS_ADDR_SCAN_CTRL, 8'h00);
		rdc(CMS_ADDR_CUR_HIGH, 8'h40, "en_keep");
		chk("en_keep", poly_taps_out, 16'ha5fe);
		slow <= 1'b0;
		range(16'h0020, 16'h0021);
		wr(CMS_ADDR_SCAN_CTRL, 8'h40);
		tick(10);
		chk("en_off", 16'(fetches), 16'h0004);
		irq_active_in <= 1'b1;
		wr(CMS_ADDR_SCAN_CTRL, 8'hca);
		wait_go();
		chk("peek", 16'(fetches), 16'h0006);
		range(16'h0030, 16'h0030);
		wr(CMS_ADDR_SCAN_CTRL, 8'hc3);
		tick(10);
		chk("trig", 16'(fetches), 16'h0006);
		trigger_in <= 1'b1;
		tick(1);
		trigger_in <= 1'b0;
		wait_go();
		chk("trig", 16'(fetches), 16'h0007);
		range(16'h0040, 16'h0047);
		wr(CMS_ADDR_SCAN_CTRL, 8'hc1);
		tick(2);
		chk("stall", 16'(cpu_stall_out), 16'h0001);
		wait_go();
		chk("burst", 16'(fetches), 16'h000f);
		chk("stall", 16'(cpu_stall_out), 16'h0000);
		end_sim();
	end
endmodule
`default_nettype wire
